// ===== cfg_pin_pkg.sv
package cfg_pin_pkg;

   // option codes
   localparam logic [3:0] OPT_DEFAULT  = 4'h0;
   localparam logic [3:0] OPT_RESERVED = 4'h1;
   localparam logic [3:0] OPT_2        = 4'h2;
   localparam logic [3:0] OPT_3        = 4'h3;
   localparam logic [3:0] OPT_4        = 4'h4;
   localparam logic [3:0] OPT_5        = 4'h5;
   localparam logic [3:0] OPT_6        = 4'h6;
   localparam logic [3:0] OPT_7        = 4'h7;
   localparam logic [3:0] OPT_8        = 4'h8;
   localparam logic [3:0] OPT_9        = 4'h9;
   localparam logic [3:0] OPT_A        = 4'hA;
   localparam logic [3:0] OPT_B        = 4'hB;
   localparam logic [3:0] OPT_C        = 4'hC;
   localparam logic [3:0] OPT_D        = 4'hD;
   localparam logic [3:0] OPT_E        = 4'hE;
   localparam logic [3:0] OPT_F        = 4'hF;

   // input current limit encoding
   localparam logic [1:0] ILIM_100  = 2'h0;
   localparam logic [1:0] ILIM_500  = 2'h1;
   localparam logic [1:0] ILIM_1500 = 2'h2;

   // register byte offsets
   localparam logic [7:0] ADDR_CONFIG = 8'h00;
   localparam logic [7:0] ADDR_STATE  = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_MASK   = 8'h0C;

   // config register fields
   localparam int CFG_OPT_LSB  = 0;
   localparam int CFG_POL_BIT  = 4;
   localparam int CFG_SRC_BIT  = 8;

   // state register fields
   localparam int ST_ILIM_LSB  = 0;
   localparam int ST_CHG_BIT   = 2;
   localparam int ST_LQ_BIT    = 3;
   localparam int ST_HALF_BIT  = 4;
   localparam int ST_LDO_BIT   = 5;
   localparam int ST_RCH_BIT   = 6;
   localparam int ST_IRQP_BIT  = 7;
   localparam int ST_PINS_LSB  = 8;

   // reset values
   localparam logic [3:0] RST_OPTION   = 4'h0;
   localparam logic       RST_POLARITY = 1'b0;
   localparam logic [6:0] RST_MASK     = 7'h00;

   localparam int N_EVT = 7;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== cfg_pin_decode.sv
`timescale 1ns/1ns
// pure decode of option code and pin levels into charger functions
module cfg_pin_decode (
   // option
   input  wire logic [3:0] option_code,
   input  wire logic       polarity,
   // synchronised pins
   input  wire logic       config_pin_one,
   input  wire logic       config_pin_two,
   input  wire logic       config_pin_three,
   // functions
   output logic      [1:0] input_current_limit,
   output logic            charge_enable,
   output logic            low_quiescent_mode,
   output logic            fast_charge_half,
   output logic            ldo_disable,
   output logic            recharge_disable,
   output logic            pin_three_is_irq
);
   logic p1;

   always_comb begin
      p1 = config_pin_one ^ polarity;
      input_current_limit = p1 ? cfg_pin_pkg::ILIM_500 : cfg_pin_pkg::ILIM_100;
      charge_enable       = 1'b0;
      low_quiescent_mode  = 1'b0;
      fast_charge_half    = 1'b0;
      ldo_disable         = 1'b0;
      recharge_disable    = 1'b0;
      pin_three_is_irq    = option_code[3];
      unique case (option_code)
         cfg_pin_pkg::OPT_DEFAULT, cfg_pin_pkg::OPT_RESERVED: begin
            low_quiescent_mode = config_pin_two;
            charge_enable      = config_pin_three;
         end
         cfg_pin_pkg::OPT_2: begin
            if (config_pin_two) input_current_limit = cfg_pin_pkg::ILIM_1500;
            low_quiescent_mode = config_pin_three;
         end
         cfg_pin_pkg::OPT_3: begin
            if (config_pin_two) input_current_limit = cfg_pin_pkg::ILIM_1500;
            fast_charge_half = config_pin_three;
         end
         cfg_pin_pkg::OPT_4: begin
            if (config_pin_two) input_current_limit = cfg_pin_pkg::ILIM_1500;
            ldo_disable = config_pin_three;
         end
         cfg_pin_pkg::OPT_5: begin
            if (config_pin_two) input_current_limit = cfg_pin_pkg::ILIM_1500;
            charge_enable = config_pin_three;
         end
         cfg_pin_pkg::OPT_6: begin
            recharge_disable = config_pin_two;
            charge_enable    = config_pin_three;
         end
         cfg_pin_pkg::OPT_7: begin
            input_current_limit = cfg_pin_pkg::ILIM_100;
            charge_enable       = p1;
            low_quiescent_mode  = config_pin_two;
            recharge_disable    = config_pin_three;
         end
         cfg_pin_pkg::OPT_8: begin
            if (config_pin_two) input_current_limit = cfg_pin_pkg::ILIM_1500;
         end
         cfg_pin_pkg::OPT_9: charge_enable = config_pin_two;
         cfg_pin_pkg::OPT_A: low_quiescent_mode = config_pin_two;
         cfg_pin_pkg::OPT_B: recharge_disable = config_pin_two;
         cfg_pin_pkg::OPT_C: fast_charge_half = config_pin_two;
         cfg_pin_pkg::OPT_D: ldo_disable = config_pin_two;
         cfg_pin_pkg::OPT_E: begin
            input_current_limit = p1 ? cfg_pin_pkg::ILIM_1500 : cfg_pin_pkg::ILIM_100;
            charge_enable       = config_pin_two;
         end
         cfg_pin_pkg::OPT_F: begin
            input_current_limit = cfg_pin_pkg::ILIM_100;
            low_quiescent_mode  = p1;
            charge_enable       = config_pin_two;
         end
      endcase
   end

endmodule

// ===== cfg_pin_top.sv
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
// Notes on behaviour
// - polarity bit inverts pin one sense
// - code 0000: limit, low-quiescent, charge enable
// - codes 0010-0101, 1000: pin two high raises limit to 1500
// - LDO disable on pin three or two
// - high level halves fast-charge current
// - codes 0101, 0110: pin three enables charging
// - codes 1xxx: pin three is interrupt
// - recharge disable when assigned pin high
module cfg_pin_top (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // factory straps
   input  wire logic [3:0]  strap_option,
   input  wire logic        strap_polarity,
   // config pins
   input  wire logic        config_pin_one,
   input  wire logic        config_pin_two,
   input  wire logic        config_pin_three_in,
   output logic             config_pin_three_out,
   output logic             config_pin_three_oe_n,
   // charger controls
   output logic [1:0]       input_current_limit,
   output logic             charge_enable,
   output logic             low_quiescent_mode,
   output logic             fast_charge_half,
   output logic             ldo_disable,
   output logic             recharge_disable,
   // interrupt
   output logic             irq
);

   ////////////////////////////////////////////////////////////////////////////
   logic [2:0] pin_s1_r, pin_s2_r;
   logic [3:0] strap_s1_r, strap_s2_r;
   logic       pol_s1_r, pol_s2_r;
   logic [3:0] option_r;
   logic       polarity_r;
   logic       use_strap_r;
   logic       strap_taken_r;
   logic [6:0] status_r, mask_r;
   logic [1:0] ilim_nxt;
   logic       chg_nxt, lq_nxt, half_nxt, ldo_nxt, rch_nxt, irqp_nxt;
   logic [6:0] func_r, func_nxt, evt;
   logic [3:0] eff_option;
   logic       eff_pol;

   // pins and straps come from outside the clock domain
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_s1_r   <= 3'h0;
         pin_s2_r   <= 3'h0;
      end else begin
         pin_s1_r   <= {config_pin_three_in, config_pin_two, config_pin_one};
         pin_s2_r   <= pin_s1_r;
      end
   end

   // straps keep shifting through reset so the latch sees them settled at release
   always_ff @(posedge aclk) begin
      strap_s1_r <= strap_option;
      strap_s2_r <= strap_s1_r;
      pol_s1_r   <= strap_polarity;
      pol_s2_r   <= pol_s1_r;
   end

   ////////////////////////////////////////////////////////////////////////////
   // software override of the factory code
   logic [3:0] sw_option_r;
   logic       sw_pol_r;

   always_comb begin
      eff_option = use_strap_r ? option_r : sw_option_r;
      eff_pol    = use_strap_r ? polarity_r : sw_pol_r;
   end

   // straps are latched once after reset release
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         strap_taken_r <= 1'b0;
         option_r      <= cfg_pin_pkg::RST_OPTION;
         polarity_r    <= cfg_pin_pkg::RST_POLARITY;
      end else if (!strap_taken_r) begin
         strap_taken_r <= 1'b1;
         option_r      <= strap_s2_r;
         polarity_r    <= pol_s2_r;
      end
   end

   cfg_pin_decode u_decode (
      .option_code         (eff_option),
      .polarity            (eff_pol),
      .config_pin_one      (pin_s2_r[0]),
      .config_pin_two      (pin_s2_r[1]),
      .config_pin_three    (pin_s2_r[2]),
      .input_current_limit (ilim_nxt),
      .charge_enable       (chg_nxt),
      .low_quiescent_mode  (lq_nxt),
      .fast_charge_half    (half_nxt),
      .ldo_disable         (ldo_nxt),
      .recharge_disable    (rch_nxt),
      .pin_three_is_irq    (irqp_nxt)
   );

   always_comb begin
      func_nxt = {irqp_nxt, rch_nxt, ldo_nxt, half_nxt, lq_nxt, chg_nxt, ilim_nxt == 2'h2};
   end

   // registered function outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         input_current_limit <= cfg_pin_pkg::ILIM_100;
         charge_enable       <= 1'b0;
         low_quiescent_mode  <= 1'b0;
         fast_charge_half    <= 1'b0;
         ldo_disable         <= 1'b0;
         recharge_disable    <= 1'b0;
         func_r              <= 7'h00;
      end else begin
         input_current_limit <= ilim_nxt;
         charge_enable       <= chg_nxt;
         low_quiescent_mode  <= lq_nxt;
         fast_charge_half    <= half_nxt;
         ldo_disable         <= ldo_nxt;
         recharge_disable    <= rch_nxt;
         func_r              <= func_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // events: any change of a decoded function, except a limit change between 100 and 500
   assign evt = func_r ^ func_nxt;

   logic rd_status;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_r <= 7'h00;
      end else begin
         // set wins over clear-on-read
         status_r <= (rd_status ? 7'h00 : status_r) | evt;
      end
   end

   assign irq = |(status_r & mask_r);

   // pin three drives the interrupt, open-drain active low
   always_comb begin
      config_pin_three_out  = 1'b0;
      config_pin_three_oe_n = !(func_r[6] && irq);
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite slave: one write and one read at a time
   logic       aw_got_r, w_got_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic       do_write;

   assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
   assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_write      = aw_got_r && w_got_r && !s_axi_bvalid;
   assign rd_status     = s_axi_arvalid && s_axi_arready &&
                          s_axi_araddr == cfg_pin_pkg::ADDR_STATUS;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r     <= 1'b0;
         w_got_r      <= 1'b0;
         awaddr_r     <= 8'h00;
         wdata_r      <= 32'h0000_0000;
         wstrb_r      <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= cfg_pin_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_got_r     <= 1'b0;
            w_got_r      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_r == cfg_pin_pkg::ADDR_CONFIG ||
                             awaddr_r == cfg_pin_pkg::ADDR_MASK) ?
                            cfg_pin_pkg::RESP_OKAY : cfg_pin_pkg::RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // writable registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sw_option_r <= cfg_pin_pkg::RST_OPTION;
         sw_pol_r    <= cfg_pin_pkg::RST_POLARITY;
         use_strap_r <= 1'b1;
         mask_r      <= cfg_pin_pkg::RST_MASK;
      end else if (do_write) begin
         if (awaddr_r == cfg_pin_pkg::ADDR_CONFIG && wstrb_r[0]) begin
            sw_option_r <= wdata_r[cfg_pin_pkg::CFG_OPT_LSB +: 4];
            sw_pol_r    <= wdata_r[cfg_pin_pkg::CFG_POL_BIT];
         end
         if (awaddr_r == cfg_pin_pkg::ADDR_CONFIG && wstrb_r[1])
            use_strap_r <= wdata_r[cfg_pin_pkg::CFG_SRC_BIT];
         if (awaddr_r == cfg_pin_pkg::ADDR_MASK && wstrb_r[0])
            mask_r <= wdata_r[6:0];
      end
   end

   // read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= cfg_pin_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= cfg_pin_pkg::RESP_OKAY;
         unique case (s_axi_araddr)
            cfg_pin_pkg::ADDR_CONFIG:
               s_axi_rdata <= {23'h0, use_strap_r, 3'h0, eff_pol, eff_option};
            cfg_pin_pkg::ADDR_STATE:
               s_axi_rdata <= {21'h0, pin_s2_r, func_r[6:1], input_current_limit};
            cfg_pin_pkg::ADDR_STATUS: s_axi_rdata <= {25'h0, status_r};
            cfg_pin_pkg::ADDR_MASK:   s_axi_rdata <= {25'h0, mask_r};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= cfg_pin_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   polarity_sense_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (eff_option == cfg_pin_pkg::OPT_DEFAULT) |=>
      input_current_limit == (($past(pin_s2_r[0]) ^ $past(eff_pol)) ? 2'h1 : 2'h0))
      else $error("pin one polarity decode wrong");

   default_charge_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (eff_option == cfg_pin_pkg::OPT_DEFAULT) |=> charge_enable == $past(pin_s2_r[2]))
      else $error("default charge enable wrong");

   high_limit_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (eff_option == cfg_pin_pkg::OPT_5 && pin_s2_r[1]) |=> input_current_limit == 2'h2)
      else $error("1500 mA not selected");

   ldo_ctrl_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (eff_option == cfg_pin_pkg::OPT_D) |=> ldo_disable == $past(pin_s2_r[1]))
      else $error("ldo control wrong");

   half_current_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (eff_option == cfg_pin_pkg::OPT_3) |=> fast_charge_half == $past(pin_s2_r[2]))
      else $error("half current wrong");

   irq_pin_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (!func_r[6]) |-> config_pin_three_oe_n)
      else $error("pin three driven when not interrupt");

   recharge_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (eff_option == cfg_pin_pkg::OPT_7) |=> recharge_disable == $past(pin_s2_r[2]))
      else $error("recharge disable wrong");

   reserved_code_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (eff_option == cfg_pin_pkg::OPT_RESERVED) |=> low_quiescent_mode == $past(pin_s2_r[1]))
      else $error("reserved code not default");

endmodule

// ===== pin_host.sv
`timescale 1ns/1ns
// system side of the three config pins; pin three line has a pull-up
module pin_host (
   // levels commanded by the bench
   input  wire logic lvl_one,
   input  wire logic lvl_two,
   input  wire logic lvl_three,
   input  wire logic release_three,
   // device side of pin three
   input  wire logic config_pin_three_out,
   input  wire logic config_pin_three_oe_n,
   // pins into the device
   output logic      config_pin_one,
   output logic      config_pin_two,
   output logic      config_pin_three_in,
   // resolved pin three line
   output logic      line_three
);
   logic dev_low;

   assign config_pin_one      = lvl_one;
   assign config_pin_two      = lvl_two;
   // open drain: device pulling low wins, a released line floats high
   assign dev_low             = !config_pin_three_oe_n && !config_pin_three_out;
   assign line_three          = dev_low ? 1'b0 : (release_three ? 1'b1 : lvl_three);
   assign config_pin_three_in = line_three;
endmodule

// ===== tb_top.sv
`timescale 1ns/1ns
module tb_top;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_rready, strap_polarity, config_pin_one, config_pin_two;
   logic        config_pin_three_in, config_pin_three_out, config_pin_three_oe_n, irq;
   logic        charge_enable, low_quiescent_mode, fast_charge_half, ldo_disable;
   logic        recharge_disable, lvl_one, lvl_two, lvl_three, release_three, line_three;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb, strap_option;
   logic [1:0]  s_axi_bresp, s_axi_rresp, input_current_limit, rsp;
   logic [6:0]  v, m;
   int          mismatches, n_compared, cycles;
   wire  [6:0]  act = {input_current_limit, charge_enable, low_quiescent_mode,
                       fast_charge_half, ldo_disable, recharge_disable};
   // per code, pin driving {chg, lq, half, ldo, rch}: 0 none, 1..3 pin one..three
   localparam logic [9:0] route [16] = '{10'h380, 10'h380, 10'h0C0, 10'h030, 10'h00C,
      10'h300, 10'h302, 10'h183, 10'h000, 10'h200, 10'h080, 10'h002, 10'h020,
      10'h008, 10'h200, 10'h240};

   cfg_pin_top u_cfg_pin_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .strap_option, .strap_polarity,
      .config_pin_one, .config_pin_two, .config_pin_three_in, .config_pin_three_out,
      .config_pin_three_oe_n, .input_current_limit, .charge_enable, .low_quiescent_mode,
      .fast_charge_half, .ldo_disable, .recharge_disable, .irq);

   pin_host u_pin_host (.lvl_one, .lvl_two, .lvl_three, .release_three,
      .config_pin_three_out, .config_pin_three_oe_n, .config_pin_one, .config_pin_two,
      .config_pin_three_in, .line_three);

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   task automatic wrap_up;
      if (mismatches == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         wrap_up();
      end
   end

   task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] seen);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic got;
      got = 1'b0;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (!got) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bready && s_axi_bvalid) begin
            r            = s_axi_bresp;
            s_axi_bready <= 1'b0;
            got          = 1'b1;
         end
      end
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic got;
      got = 1'b0;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      while (!got) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rready && s_axi_rvalid) begin
            d            = s_axi_rdata;
            r            = s_axi_rresp;
            s_axi_rready <= 1'b0;
            got          = 1'b1;
         end
      end
   endtask

   // expected function levels and the mask of functions that the code assigns
   function automatic logic [6:0] exp_fn(input logic [3:0] c, input logic pol,
                                         input logic [2:0] p, output logic [6:0] mk);
      logic [6:0] ev;
      logic [3:0] pl;
      logic [1:0] sel;
      pl = {p[2], p[1], p[0] ^ pol, 1'b0};
      ev = 7'h00;
      ev[6:5] = pl[1] ? cfg_pin_pkg::ILIM_500 : cfg_pin_pkg::ILIM_100;
      if (p[1] && (c inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h8})) ev[6:5] = cfg_pin_pkg::ILIM_1500;
      if (c == 4'hE) ev[6:5] = pl[1] ? cfg_pin_pkg::ILIM_1500 : cfg_pin_pkg::ILIM_100;
      mk = (c == 4'h7 || c == 4'hF) ? 7'h00 : 7'h60;
      for (int f = 0; f < 5; f++) begin
         sel   = route[c][2*f +: 2];
         ev[f] = pl[sel];
         mk[f] = (sel != 2'h0);
      end
      return ev & mk;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'hF;
      strap_option = 4'h0;
      strap_polarity = 1'b0;
      {lvl_one, lvl_two, lvl_three, release_three} = 4'h0;
      mismatches = 0;
      n_compared = 0;
      cycles = 0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(cfg_pin_pkg::ADDR_CONFIG, rd, rsp);
      cmp("config reset", 32'h0000_0100, rd);
      axi_rd(cfg_pin_pkg::ADDR_MASK, rd, rsp);
      cmp("mask reset", 32'h0000_0000, rd);
      axi_rd(8'h10, rd, rsp);
      cmp("unmapped resp", {30'h0, cfg_pin_pkg::RESP_SLVERR}, {30'h0, rsp});
      cmp("unmapped data", 32'h0000_0000, rd);
      axi_wr(cfg_pin_pkg::ADDR_STATE, 32'hFFFF_FFFF, rsp);
      cmp("state write resp", {30'h0, cfg_pin_pkg::RESP_SLVERR}, {30'h0, rsp});
      for (int pol = 0; pol < 2; pol++) begin
         for (int c = 0; c < 16; c++) begin
            axi_wr(cfg_pin_pkg::ADDR_CONFIG, {27'h0, 1'(pol), 4'(c)}, rsp);
            release_three <= c[3];
            for (int p = 0; p < 8; p++) begin
               lvl_one <= p[0];
               lvl_two <= p[1];
               lvl_three <= p[2];
               repeat (5) @(posedge aclk);
               v = exp_fn(4'(c), 1'(pol), 3'(p), m);
               cmp("functions", {25'h0, v}, {25'h0, act & m});
               cmp("pin three enable", 32'h1, {31'h0, config_pin_three_oe_n});
            end
            axi_rd(cfg_pin_pkg::ADDR_STATE, rd, rsp);
            cmp("pin three role", {31'h0, 1'(c >> 3)}, {31'h0, rd[7]});
            axi_rd(cfg_pin_pkg::ADDR_CONFIG, rd, rsp);
            cmp("config readback", {27'h0, 1'(pol), 4'(c)}, rd);
         end
      end
      // interrupt on pin three: raise, clear by read, then masked
      axi_wr(cfg_pin_pkg::ADDR_CONFIG, 32'h0000_0008, rsp);
      release_three <= 1'b1;
      lvl_one <= 1'b0;
      lvl_two <= 1'b0;
      repeat (5) @(posedge aclk);
      axi_rd(cfg_pin_pkg::ADDR_STATUS, rd, rsp);
      axi_wr(cfg_pin_pkg::ADDR_MASK, 32'h0000_0001, rsp);
      axi_rd(cfg_pin_pkg::ADDR_MASK, rd, rsp);
      cmp("mask readback", 32'h0000_0001, rd);
      lvl_two <= 1'b1;
      repeat (5) @(posedge aclk);
      cmp("irq raised", 32'h1, {31'h0, irq});
      cmp("pin three line low", 32'h0, {31'h0, line_three});
      axi_rd(cfg_pin_pkg::ADDR_STATUS, rd, rsp);
      cmp("status event", 32'h0000_0001, rd);
      repeat (2) @(posedge aclk);
      cmp("irq cleared", 32'h0, {31'h0, irq});
      cmp("pin three released", 32'h1, {31'h0, line_three});
      axi_rd(cfg_pin_pkg::ADDR_STATUS, rd, rsp);
      cmp("status after read", 32'h0000_0000, rd);
      axi_wr(cfg_pin_pkg::ADDR_MASK, 32'h0000_0000, rsp);
      lvl_two <= 1'b0;
      repeat (5) @(posedge aclk);
      cmp("irq masked", 32'h0, {31'h0, irq});
      axi_rd(cfg_pin_pkg::ADDR_STATUS, rd, rsp);
      cmp("status masked event", 32'h0000_0001, rd);
      // second reset with straps at code 1111, pin one active low
      strap_option <= 4'hF;
      strap_polarity <= 1'b1;
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(cfg_pin_pkg::ADDR_CONFIG, rd, rsp);
      cmp("config straps", 32'h0000_011F, rd);
      repeat (5) @(posedge aclk);
      v = exp_fn(4'hF, 1'b1, 3'h0, m);
      cmp("strap functions", {25'h0, v}, {25'h0, act & m});
      wrap_up();
   end
endmodule
